// [hdl/mbc_sequencer.v]
/*
 * Motor bypass contactor sequencer: moves the motor between converter feed
 * and direct line feed, with AXI4-Lite registers and one interrupt line.
 * Assumes contactor feedback pins are asynchronous and one 100 MHz clock.
 */
`timescale 1ns/1ps
`include "mbc_regs.vh"

module mbc_sequencer
#(
	parameter TICK_CYCLES = `MBC_TICK_CYCLES,
	parameter TW = 16
)
(
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address and data
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Contactors
	output reg inverter_side_contactor,
	output reg line_side_contactor,
	input wire inverter_fb_pin,
	input wire line_fb_pin,
	// Drive interface
	output reg pulse_enable,
	output reg catch_request,
	output reg temp_supervision,
	input wire catch_done,
	// Interrupt
	output reg irq
);

	// ****************************************
	// States
	// ****************************************
	localparam [7:0] ST_POWERUP = 8'h01;
	localparam [7:0] ST_INVERTER = 8'h02;
	localparam [7:0] ST_ENTRY = 8'h04;
	localparam [7:0] ST_DEAD_IN = 8'h08;
	localparam [7:0] ST_BYPASS = 8'h10;
	localparam [7:0] ST_DEAD_OUT = 8'h20;
	localparam [7:0] ST_CATCH = 8'h40;
	localparam [7:0] ST_FAULT = 8'h80;

	// ****************************************
	// Registers and internal state
	// ****************************************
	reg [31:0] config_reg;
	reg [31:0] control;
	reg [TW-1:0] dead_ms;
	reg [TW-1:0] return_ms;
	reg [TW-1:0] entry_ms;
	reg [TW-1:0] watch_ms;
	reg [31:0] bypass_speed_threshold;
	reg [31:0] speed_setpoint;
	reg [2:0] irq_status;
	reg [2:0] irq_enable;
	reg [7:0] state;
	reg ready_state_bit;
	reg [2:0] inv_sync;
	reg [2:0] line_sync;
	reg inv_fb;
	reg line_fb;
	reg [7:0] aw_addr;
	reg aw_held;
	reg [31:0] w_data;
	reg w_held;
	reg powerup_done;
	reg tmr_load;
	reg [TW-1:0] tmr_ms;
	reg wtmr_load;
	reg [2:0] event_set;
	wire tmr_done;
	wire wtmr_done;
	wire bypass_cmd_wanted;
	wire bypass_speed_wanted;
	wire want_bypass;
	wire hard_stop;
	wire fly_ok;
	wire bypass_active_bit;
	wire wr_fire;

	// Field helper used by several register loads
	function [TW-1:0] time_field;
		input [31:0] d;
		begin
			time_field = d[TW-1:0];
		end
	endfunction

	// ****************************************
	// Timers
	// ****************************************
	mbc_timer #(.TICK_CYCLES(TICK_CYCLES), .WIDTH(TW)) u_seq_tmr
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.load(tmr_load),
		.load_ms(tmr_ms),
		.done(tmr_done)
	);

	mbc_timer #(.TICK_CYCLES(TICK_CYCLES), .WIDTH(TW)) u_watch_tmr
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.load(wtmr_load),
		.load_ms(watch_ms),
		.done(wtmr_done)
	);

	// ****************************************
	// Feedback synchronisers
	// ****************************************
	// feedback read
	// Three stages; the level changes only once stages two and three agree
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			inv_sync <= 3'h0;
			line_sync <= 3'h0;
			inv_fb <= 1'b0;
			line_fb <= 1'b0;
		end
		else
		begin
			inv_sync <= {inv_sync[1:0], inverter_fb_pin};
			line_sync <= {line_sync[1:0], line_fb_pin};
			if (inv_sync[1] == inv_sync[2])
				inv_fb <= inv_sync[2];
			if (line_sync[1] == line_sync[2])
				line_fb <= line_sync[2];
		end
	end

	// ****************************************
	// Trigger decode
	// ****************************************
	// trigger select
	assign bypass_cmd_wanted = config_reg[`MBC_CFG_BY_CMD] & control[`MBC_CTL_BYPASS] & control[`MBC_CTL_RUN];
	assign bypass_speed_wanted = config_reg[`MBC_CFG_BY_SPEED] & control[`MBC_CTL_RUN]
		& (speed_setpoint > bypass_speed_threshold);
	// Without a usable flying restart mode the return could not catch the motor
	assign fly_ok = (config_reg[`MBC_CFG_FLY_LSB+3:`MBC_CFG_FLY_LSB] == `MBC_FLY_MODE_A)
		| (config_reg[`MBC_CFG_FLY_LSB+3:`MBC_CFG_FLY_LSB] == `MBC_FLY_MODE_B);
	assign want_bypass = (bypass_cmd_wanted | bypass_speed_wanted) & fly_ok;
	assign hard_stop = control[`MBC_CTL_COAST_STOP] | control[`MBC_CTL_QUICK_STOP];
	assign bypass_active_bit = (state == ST_BYPASS);

	// ****************************************
	// Sequencer
	// ****************************************
	// Contactor outputs are registered; any non-listed state goes to ST_FAULT and leaves both as they were
	always @(posedge aclk)
	begin
		tmr_load <= 1'b0;
		wtmr_load <= 1'b0;
		event_set <= 3'h0;
		if (!aresetn)
		begin
			state <= ST_POWERUP;
			inverter_side_contactor <= 1'b0;
			line_side_contactor <= 1'b0;
			pulse_enable <= 1'b0;
			catch_request <= 1'b0;
			ready_state_bit <= 1'b0;
			temp_supervision <= 1'b0;
			tmr_ms <= {TW{1'b0}};
			powerup_done <= 1'b0;
		end
		else
		begin
			temp_supervision <= ready_state_bit | pulse_enable;
			case (state)
			ST_POWERUP:
			begin
				// Wait a watch interval so the feedback synchronisers settle
				if (!powerup_done)
				begin
					powerup_done <= 1'b1;
					wtmr_load <= 1'b1;
				end
				// Done is stale until the load pulse has reached the timer
				else if (wtmr_done && !wtmr_load)
				begin
					ready_state_bit <= 1'b1;
					if (config_reg[`MBC_CFG_BY_CMD] && line_fb && !inv_fb && bypass_cmd_wanted
						&& config_reg[`MBC_CFG_ARST_LSB+3:`MBC_CFG_ARST_LSB] == `MBC_AUTO_RESTART_BYPASS)
					begin
						line_side_contactor <= 1'b1;
						state <= ST_BYPASS;
						wtmr_load <= 1'b1;
					end
					else
					begin
						inverter_side_contactor <= 1'b1;
						pulse_enable <= control[`MBC_CTL_RUN];
						state <= ST_INVERTER;
						wtmr_load <= 1'b1;
					end
				end
			end
			ST_INVERTER:
			begin
				pulse_enable <= control[`MBC_CTL_RUN] & ~hard_stop & ~control[`MBC_CTL_RAMP_STOP];
				if (want_bypass && !hard_stop)
				begin
					tmr_ms <= entry_ms;
					tmr_load <= 1'b1;
					state <= ST_ENTRY;
				end
			end
			ST_ENTRY:
			begin
				if (!want_bypass)
					state <= ST_INVERTER;
				else if (tmr_done && !tmr_load)
				begin
					pulse_enable <= 1'b0;
					inverter_side_contactor <= 1'b0;
					tmr_ms <= dead_ms;
					tmr_load <= 1'b1;
					wtmr_load <= 1'b1;
					state <= ST_DEAD_IN;
				end
			end
			ST_DEAD_IN:
			begin
				// close line side after dead time
				// only when inverter side confirmed open
				if (tmr_done && !tmr_load && !inv_fb)
				begin
					line_side_contactor <= 1'b1;
					wtmr_load <= 1'b1;
					event_set[`MBC_EV_ENTER] <= 1'b1;
					state <= ST_BYPASS;
				end
			end
			ST_BYPASS:
			begin
				// coast or quick stop leave line operation
				if (hard_stop || !want_bypass)
				begin
					if (!hard_stop)
					begin
						tmr_ms <= return_ms;
						tmr_load <= 1'b1;
					end
					else
						tmr_ms <= {TW{1'b0}};
					state <= ST_DEAD_OUT;
					catch_request <= 1'b0;
				end
			end
			ST_DEAD_OUT:
			begin
				// return delay (none on coast or quick stop), then open line and wait dead time
				if (line_side_contactor && tmr_done && !tmr_load)
				begin
					line_side_contactor <= 1'b0;
					tmr_ms <= dead_ms;
					tmr_load <= 1'b1;
					wtmr_load <= 1'b1;
				end
				else if (!line_side_contactor && tmr_done && !tmr_load && !line_fb)
				begin
					inverter_side_contactor <= 1'b1;
					wtmr_load <= 1'b1;
					if (hard_stop)
						state <= ST_INVERTER;
					else
					begin
						catch_request <= 1'b1;
						state <= ST_CATCH;
					end
				end
			end
			ST_CATCH:
			begin
				if (catch_done)
				begin
					catch_request <= 1'b0;
					pulse_enable <= 1'b1;
					event_set[`MBC_EV_LEAVE] <= 1'b1;
					state <= ST_INVERTER;
				end
			end
			ST_FAULT:
			begin
				if (control[`MBC_CTL_FAULT_ACK] && !inv_fb && !line_fb)
					state <= ST_POWERUP;
				powerup_done <= 1'b0;
			end
			default:
				state <= ST_FAULT;
			endcase
			if (state != ST_FAULT && state != ST_POWERUP && wtmr_done && !wtmr_load
				&& (inv_fb != inverter_side_contactor || line_fb != line_side_contactor))
			begin
				inverter_side_contactor <= 1'b0;
				line_side_contactor <= 1'b0;
				pulse_enable <= 1'b0;
				catch_request <= 1'b0;
				ready_state_bit <= 1'b0;
				event_set[`MBC_EV_FAULT] <= 1'b1;
				state <= ST_FAULT;
			end
		end
	end

	// ****************************************
	// AXI4-Lite write path
	// ****************************************
	assign wr_fire = aw_held & w_held & ~s_axi_bvalid;

	// Address and data captured in either order; response after both
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			config_reg <= `MBC_CFG_RESET;
			control <= 32'h0000_0000;
			dead_ms <= time_field(`MBC_TIME_RESET);
			return_ms <= time_field(`MBC_TIME_RESET);
			entry_ms <= time_field(`MBC_TIME_RESET);
			watch_ms <= time_field(`MBC_TIME_RESET);
			bypass_speed_threshold <= 32'h0000_0000;
			speed_setpoint <= 32'h0000_0000;
			irq_status <= 3'h0;
			irq_enable <= 3'h0;
			irq <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_addr <= s_axi_awaddr;
				aw_held <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_data <= s_axi_wdata;
				w_held <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			// Clear first, then event set, so a same-cycle event is kept
			if (wr_fire && aw_addr == `MBC_OFF_IRQ_CLR)
				irq_status <= (irq_status & ~w_data[2:0]) | event_set;
			else
				irq_status <= irq_status | event_set;
			irq <= |(irq_status & irq_enable);
			if (wr_fire)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				case (aw_addr)
				`MBC_OFF_CONFIG: config_reg <= w_data;
				`MBC_OFF_CONTROL: control <= w_data;
				`MBC_OFF_DEAD: dead_ms <= time_field(w_data);
				`MBC_OFF_RETURN: return_ms <= time_field(w_data);
				`MBC_OFF_ENTRY: entry_ms <= time_field(w_data);
				`MBC_OFF_THRESH: bypass_speed_threshold <= w_data;
				`MBC_OFF_WATCH: watch_ms <= time_field(w_data);
				`MBC_OFF_IRQ_EN: irq_enable <= w_data[2:0];
				`MBC_OFF_SETPOINT: speed_setpoint <= w_data;
				`MBC_OFF_STATUS, `MBC_OFF_IRQ_STAT, `MBC_OFF_IRQ_CLR: s_axi_bresp <= 2'h0;
				default: s_axi_bresp <= 2'h2;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ****************************************
	// AXI4-Lite read path
	// ****************************************
	// One read at a time; arready drops until rdata is taken
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
			`MBC_OFF_CONFIG: s_axi_rdata <= config_reg;
			`MBC_OFF_CONTROL: s_axi_rdata <= control;
			`MBC_OFF_DEAD: s_axi_rdata <= {{(32-TW){1'b0}}, dead_ms};
			`MBC_OFF_RETURN: s_axi_rdata <= {{(32-TW){1'b0}}, return_ms};
			`MBC_OFF_ENTRY: s_axi_rdata <= {{(32-TW){1'b0}}, entry_ms};
			`MBC_OFF_THRESH: s_axi_rdata <= bypass_speed_threshold;
			`MBC_OFF_WATCH: s_axi_rdata <= {{(32-TW){1'b0}}, watch_ms};
			`MBC_OFF_STATUS: s_axi_rdata <= {16'h0000, state, 2'h0, temp_supervision, catch_request,
				pulse_enable, (state == ST_FAULT), bypass_active_bit, ready_state_bit};
			`MBC_OFF_IRQ_STAT: s_axi_rdata <= {29'h0000_0000, irq_status};
			`MBC_OFF_IRQ_EN: s_axi_rdata <= {29'h0000_0000, irq_enable};
			`MBC_OFF_IRQ_CLR: s_axi_rdata <= 32'h0000_0000;
			`MBC_OFF_SETPOINT: s_axi_rdata <= speed_setpoint;
			default:
			begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'h2;
			end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

// [inc/mbc_regs.vh]
/*
 * Register map, field positions, reset values and timing counts for the
 * motor bypass contactor sequencer.
 * Assumes a 32-bit AXI4-Lite slave port and a 100 MHz control clock.
 */
`ifndef MBC_REGS_VH
`define MBC_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define MBC_OFF_CONFIG 8'h00
`define MBC_OFF_CONTROL 8'h04
`define MBC_OFF_DEAD 8'h08
`define MBC_OFF_RETURN 8'h0C
`define MBC_OFF_ENTRY 8'h10
`define MBC_OFF_THRESH 8'h14
`define MBC_OFF_WATCH 8'h18
`define MBC_OFF_STATUS 8'h1C
`define MBC_OFF_IRQ_STAT 8'h20
`define MBC_OFF_IRQ_EN 8'h24
`define MBC_OFF_IRQ_CLR 8'h28
`define MBC_OFF_SETPOINT 8'h2C

// ****************************************
// Field positions
// ****************************************
// Configuration
`define MBC_CFG_BY_CMD 0
`define MBC_CFG_BY_SPEED 1
`define MBC_CFG_FLY_LSB 4
`define MBC_CFG_ARST_LSB 8
// Control
`define MBC_CTL_RUN 0
`define MBC_CTL_BYPASS 1
`define MBC_CTL_RAMP_STOP 2
`define MBC_CTL_COAST_STOP 3
`define MBC_CTL_QUICK_STOP 4
`define MBC_CTL_FAULT_ACK 5
// Status
`define MBC_ST_READY 0
`define MBC_ST_BYPASS 1
`define MBC_ST_FAULT 2
`define MBC_ST_PULSE_EN 3
`define MBC_ST_CATCH 4
`define MBC_ST_TEMP_SUP 5
`define MBC_ST_STATE_LSB 8
// Interrupt events
`define MBC_EV_ENTER 0
`define MBC_EV_LEAVE 1
`define MBC_EV_FAULT 2

// ****************************************
// Reset values and timing
// ****************************************
`define MBC_CFG_RESET 32'h0000_0000
`define MBC_TIME_RESET 32'h0000_0064
`define MBC_AUTO_RESTART_BYPASS 4'h4
`define MBC_FLY_MODE_A 4'h1
`define MBC_FLY_MODE_B 4'h4
`define MBC_CLK_MHZ 100
`define MBC_TICK_US 1000
`define MBC_TICK_CYCLES (`MBC_CLK_MHZ * `MBC_TICK_US)

`endif

// [hdl/mbc_timer.v]
/*
 * Millisecond down-counter used for every sequencer delay.
 * Assumes a one-cycle load pulse from the sequencer on the same clock.
 */
`timescale 1ns/1ps
`include "mbc_regs.vh"

module mbc_timer
#(
	parameter TICK_CYCLES = `MBC_TICK_CYCLES,
	parameter WIDTH = 16
)
(
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Control
	input wire load,
	input wire [WIDTH-1:0] load_ms,
	// Result
	output reg done
);

	reg [31:0] tick;
	reg [WIDTH-1:0] remain;

	// Prescaler and ms countdown; done stays high until reloaded
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tick <= 32'h0000_0000;
			remain <= {WIDTH{1'b0}};
			done <= 1'b0;
		end
		else if (load)
		begin
			tick <= 32'h0000_0000;
			remain <= load_ms;
			done <= 1'b0;
		end
		else if (remain == {WIDTH{1'b0}})
			done <= 1'b1;
		else if (tick == TICK_CYCLES - 1)
		begin
			tick <= 32'h0000_0000;
			remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
		end
		else
			tick <= tick + 32'h0000_0001;
	end

endmodule

// [sim/mbc_contactor_model.sv]
/*
 * Behavioural pair of contactors with feedback contacts, plus drive catch.
 * Assumes the sequencer clock; commands and feedback are high for closed.
 */
`timescale 1ns/1ps

module mbc_contactor_model
(
	// Clock
	input wire aclk,
	// Commands from the sequencer
	input wire inv_cmd,
	input wire line_cmd,
	input wire catch_req,
	// Scenario controls
	input wire jam_inv,
	input wire ext_line,
	// Feedback to the sequencer
	output wire inv_fb,
	output wire line_fb,
	output wire catch_done
);
	// ****************************************
	// Contact travel
	// ****************************************
	logic [3:0] inv_p = 4'h0;
	logic [3:0] line_p = 4'h0;
	logic [3:0] cat_p = 4'h0;

	// Four-cycle travel, so feedback never mirrors the command at once
	always @(posedge aclk)
	begin
		inv_p <= {inv_p[2:0], inv_cmd};
		line_p <= {line_p[2:0], line_cmd};
		cat_p <= {cat_p[2:0], catch_req};
	end

	assign inv_fb = inv_p[3] & ~jam_inv; // Jam keeps it from closing
	assign line_fb = line_p[3] | ext_line;
	assign catch_done = cat_p[3] & catch_req;
endmodule

// [sim/mbc_seq_monitor.sv]
/*
 * Checker for the bypass sequencer: interlock, changeover order, dead time.
 * Assumes it is bound to the sequencer top and sees only its ports.
 */
`timescale 1ns/1ps

module mbc_seq_monitor
(
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Register bus
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	// Contactors and drive
	input wire inverter_side_contactor,
	input wire line_side_contactor,
	input wire inverter_fb_pin,
	input wire line_fb_pin,
	input wire pulse_enable,
	input wire catch_request,
	input wire temp_supervision
);
	default clocking mc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ****************************************
	// Assertions
	// ****************************************
	a_never_both: assert property (!(inverter_side_contactor && line_side_contactor))
		else $error("both contactors closed");
	a_line_after_open: assert property ($rose(line_side_contactor) |-> !inverter_fb_pin)
		else $error("line closed while inverter contact closed");
	a_pulses_off_line: assert property (line_side_contactor |-> !pulse_enable)
		else $error("pulses enabled on line");
	a_inv_after_open: assert property ($rose(inverter_side_contactor) |-> !line_fb_pin)
		else $error("inverter closed while line contact closed");
	a_dead_entry: assert property ($fell(inverter_side_contactor) |=> !line_side_contactor [*8])
		else $error("dead time short on entry");
	a_dead_return: assert property ($fell(line_side_contactor) |=> !inverter_side_contactor [*8])
		else $error("dead time short on return");
	a_catch_off_line: assert property (catch_request |-> !line_side_contactor)
		else $error("catch while on line");
	a_temp_bypass: assert property (line_side_contactor && $past(line_side_contactor, 4) |-> temp_supervision)
		else $error("temperature watch off in bypass");
	a_reset_drop: assert property (disable iff (1'b0) !aresetn |=>
		!line_side_contactor && !inverter_side_contactor)
		else $error("contactor held through reset");
	a_bus_idle: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted before response");
endmodule

bind mbc_sequencer mbc_seq_monitor mon_u
(
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .inverter_side_contactor(inverter_side_contactor),
	.line_side_contactor(line_side_contactor), .inverter_fb_pin(inverter_fb_pin), .line_fb_pin(line_fb_pin),
	.pulse_enable(pulse_enable), .catch_request(catch_request), .temp_supervision(temp_supervision)
);

// [sim/tb.sv]
/*
 * Self-checking bench for the bypass sequencer with a contactor model.
 * Assumes a 10-cycle millisecond tick and the register map of the header.
 */
`timescale 1ns/1ps
`include "mbc_regs.vh"

module tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awa = 8'h00;
	logic [7:0] ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, jam = 1'b0, ext = 1'b0;
	wire awr, wrd, bv, arr, rv, isc, lsc, ifb, lfb, pen, crq, tsup, cdn, irq;
	wire [1:0] br, rrs;
	wire [31:0] rdt;
	wire [2:0] ob = {pen, isc, lsc};
	logic [1:0] bres, rres;
	logic [31:0] rdv;
	logic [7:0] ra [9];
	logic [31:0] rw [9], rx [9];
	integer checks = 0, n_fail = 0;

	// 100 MHz clock
	always #5 aclk = ~aclk;

	mbc_sequencer #(.TICK_CYCLES(10)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rrs), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .inverter_side_contactor(isc), .line_side_contactor(lsc),
		.inverter_fb_pin(ifb), .line_fb_pin(lfb), .pulse_enable(pen), .catch_request(crq),
		.temp_supervision(tsup), .catch_done(cdn), .irq(irq));

	mbc_contactor_model mdl_u (.aclk(aclk), .inv_cmd(isc), .line_cmd(lsc), .catch_req(crq),
		.jam_inv(jam), .ext_line(ext), .inv_fb(ifb), .line_fb(lfb), .catch_done(cdn));

	// ****************************************
	// Helpers
	// ****************************************
	task tally_and_finish;
		begin
			$display("checks=%0d n_fail=%0d", checks, n_fail);
			if (n_fail == 0 && checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask

	task chk(input [31:0] g, input [31:0] e);
		begin
			checks = checks + 1;
			if (g !== e)
			begin
				n_fail = n_fail + 1;
				$display("MISMATCH t=%0t seen=%h exp=%h", $time, g, e);
			end
		end
	endtask

	// Spent bound ends the run as a failure
	task to(input integer n);
		begin
			if (n >= 3000)
			begin
				chk(n, 0);
				tally_and_finish;
			end
		end
	endtask

	// Write: both channels offered together, each dropped on its own handshake
	task wr(input [7:0] a, input [31:0] d);
		integer n;
		begin
			awa <= a;
			wd <= d;
			awv <= 1'b1;
			wv <= 1'b1;
			bry <= 1'b1;
			n = 0;
			do
			begin
				@(posedge aclk);
				if (awr === 1'b1)
					awv <= 1'b0;
				if (wrd === 1'b1)
					wv <= 1'b0;
				n = n + 1;
			end
			while (bv !== 1'b1 && n < 3000);
			bres = br;
			bry <= 1'b0;
			@(posedge aclk);
			to(n);
		end
	endtask

	task rd(input [7:0] a);
		integer n;
		begin
			ara <= a;
			arv <= 1'b1;
			rry <= 1'b1;
			n = 0;
			do
			begin
				@(posedge aclk);
				if (arr === 1'b1)
					arv <= 1'b0;
				n = n + 1;
			end
			while (rv !== 1'b1 && n < 3000);
			rdv = rdt;
			rres = rrs;
			rry <= 1'b0;
			@(posedge aclk);
			to(n);
		end
	endtask

	// Wait for output s (0 line, 1 inverter, 2 pulses) to reach v
	task wt(input integer s, input logic v);
		integer n;
		begin
			n = 0;
			while (ob[s] !== v && n < 3000)
			begin
				@(posedge aclk);
				n = n + 1;
			end
			to(n);
		end
	endtask

	task rows(input bit ck);
		integer i;
		begin
			for (i = 0; i < 9; i = i + 1)
			begin
				wr(ra[i], rw[i]);
				rd(ra[i]);
				if (ck)
				begin
					chk(bres, 32'h0);
					chk(rdv, rx[i]);
				end
			end
		end
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	initial
	begin
		ra = '{`MBC_OFF_CONFIG, `MBC_OFF_DEAD, `MBC_OFF_RETURN, `MBC_OFF_ENTRY, `MBC_OFF_THRESH,
			`MBC_OFF_WATCH, `MBC_OFF_IRQ_EN, `MBC_OFF_SETPOINT, `MBC_OFF_IRQ_CLR};
		rw = '{32'h11, 32'h2, 32'h1, 32'h1, 32'h64, 32'h5, 32'h7, 32'hC8, 32'h7};
		rx = '{32'h11, 32'h2, 32'h1, 32'h1, 32'h64, 32'h5, 32'h7, 32'hC8, 32'h0};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rows(1);
		$display("test rows done");
		// Reset values and an unmapped write
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`MBC_OFF_CONFIG);
		chk(rdv, `MBC_CFG_RESET);
		rd(`MBC_OFF_WATCH);
		chk(rdv, `MBC_TIME_RESET);
		wr(8'h40, 32'h1);
		chk(bres, 32'h2);
		rd(8'h40);
		chk(rres, 32'h2);
		rows(0);
		$display("test reset done");
		// Command-triggered entry
		wr(`MBC_OFF_CONTROL, 32'h1);
		wt(1, 1'b1);
		wt(2, 1'b1);
		wr(`MBC_OFF_CONTROL, 32'h3);
		wt(0, 1'b1);
		chk(isc, 32'h0);
		chk(pen, 32'h0);
		chk(tsup, 32'h1);
		rd(`MBC_OFF_STATUS);
		chk(rdv[1:0], 32'h3);
		chk(irq, 32'h1);
		rd(`MBC_OFF_IRQ_STAT);
		chk(rdv, 32'h1);
		wr(`MBC_OFF_IRQ_CLR, 32'h7);
		@(posedge aclk);
		chk(irq, 32'h0);
		$display("test command_entry done");
		// Ramp stop ignored, then masked return event
		wr(`MBC_OFF_CONTROL, 32'h7);
		repeat (200) @(posedge aclk);
		chk(lsc, 32'h1);
		wr(`MBC_OFF_IRQ_EN, 32'h1);
		wr(`MBC_OFF_CONTROL, 32'h1);
		wt(0, 1'b0);
		wt(2, 1'b1);
		chk(isc, 32'h1);
		chk(irq, 32'h0);
		rd(`MBC_OFF_IRQ_STAT);
		chk(rdv, 32'h2);
		wr(`MBC_OFF_IRQ_EN, 32'h7);
		chk(irq, 32'h1);
		wr(`MBC_OFF_IRQ_CLR, 32'h7);
		$display("test return done");
		// Speed-triggered mode with a coast stop in bypass
		wr(`MBC_OFF_CONFIG, 32'h42); // flying mode 4
		wt(0, 1'b1);
		wr(`MBC_OFF_CONTROL, 32'h9);
		wt(0, 1'b0);
		wr(`MBC_OFF_CONTROL, 32'h0);
		repeat (100) @(posedge aclk);
		wr(`MBC_OFF_CONTROL, 32'h1);
		wt(0, 1'b1);
		wr(`MBC_OFF_SETPOINT, 32'h32);
		wt(0, 1'b0);
		wt(1, 1'b1);
		chk(crq, 32'h1);
		$display("test speed done");
		// Inverter contact fails to close
		jam <= 1'b1;
		wt(1, 1'b0);
		chk(lsc, 32'h0);
		rd(`MBC_OFF_STATUS);
		chk(rdv[2], 32'h1);
		jam <= 1'b0;
		wr(`MBC_OFF_CONTROL, 32'h20);
		rd(`MBC_OFF_STATUS);
		chk(rdv[2], 32'h0);
		$display("test fault done");
		// Power-up with motor already on line
		aresetn <= 1'b0;
		ext <= 1'b1;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		wr(`MBC_OFF_CONFIG, 32'h411);
		wr(`MBC_OFF_CONTROL, 32'h3);
		wt(0, 1'b1);
		chk(isc, 32'h0);
		rd(`MBC_OFF_STATUS);
		chk(rdv[1:0], 32'h3);
		chk(tsup, 32'h1);
		aresetn <= 1'b0;
		ext <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(lsc, 32'h0);
		$display("test power_up done");
		tally_and_finish;
	end
endmodule
